// ---- hw/sbcr_pkg.sv ----
// Purpose: shared constants and carrier types for the secondary bus clock, reset and arbitration mode block
// Assumes: system clock of 100 MHz; secondary bus clock arrives as a plain pin and is sampled
// Notes:   secondary reset control bit position and its register offset are kept for reference
package sbcr_pkg;
	localparam int unsigned          SEC_CLK_COUNT     = 10;      // number of fanned-out secondary clocks
	localparam logic [7:0]           BRIDGE_CTRL_OFS   = 8'h3E;   // offset of the bridge control register
	localparam int unsigned          SEC_RST_BIT_POS   = 6;       // secondary reset control bit position
	localparam logic [1:0]           RST_SYNC_RESET    = 2'h0;    // reset synchroniser value under reset
	localparam logic [1:0]           PIN_SYNC_RESET    = 2'h0;    // pin synchroniser value under reset

	// arbitration mode, captured from the strap after reset release
	typedef enum logic [1:0] {
		SBCR_ARB_UNKNOWN  = 2'h0, // strap not yet captured
		SBCR_ARB_INTERNAL = 2'h1, // internal arbiter serves request/grant zero
		SBCR_ARB_EXTERNAL = 2'h2  // external arbiter; pins swap roles, one bit from unknown
	} sbcr_arb_mode_e;

	// request-zero / grant-zero pin group as seen at the block edge
	typedef struct packed {
		logic req_zero_in;  // level sampled from the request-zero pin
		logic gnt_zero_out; // level driven on the grant-zero pin
	} sbcr_arb_pins_s;
endpackage

// ---- hw/sbcr_top.sv ----
// Purpose: secondary clock fan-out, secondary bus reset, and arbitration mode steering
// Assumes: all pins are asynchronous to clk_sys_i; link clock is sampled, not used as a clock
// Notes:   the secondary reset output is purely combinational by design
`timescale 1ns/1ps

module sbcr_top #(
	parameter int unsigned CLK_COUNT = sbcr_pkg::SEC_CLK_COUNT // fan-out width
) (
	input  wire logic                 clk_sys_i,          // system clock, 100 MHz
	input  wire logic                 nrst_i,             // async active-low reset
	input  wire logic                 sec_clk_i,          // secondary bus clock input pin
	input  wire logic                 ext_arb_enable_i,   // strap: high selects external arbiter
	input  wire logic                 pri_reset_signal_n_i, // primary reset, active low
	input  wire logic                 sec_rst_ctrl_i,     // secondary reset control bit from bridge control
	input  wire logic                 sec_request_zero_i, // request-zero pin level
	input  wire logic                 int_grant_zero_i,   // grant from the internal arbiter
	input  wire logic                 bridge_req_i,       // bridge wants the secondary bus
	output logic [CLK_COUNT-1:0]      sec_clk_fanout_o,   // fanned-out secondary clocks
	output logic                      sec_reset_signal_n_o, // secondary bus reset, active low
	output logic                      sec_grant_zero_o,   // grant-zero pin level
	output logic                      int_request_zero_o, // request-zero routed to internal arbiter
	output logic                      bridge_gnt_o,       // grant seen by bridge in external mode
	output logic                      ext_mode_o,         // captured arbitration mode is external
	output logic                      sec_clk_rise_o      // one-cycle pulse on a secondary clock rise
);

	////////////////////////////////////////////////////////////////////////////////
	// reset release synchroniser
	logic [1:0] rst_sync_ff;      // two-stage release chain
	logic       rst_n;            // synchronised reset used everywhere else

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_ff <= sbcr_pkg::RST_SYNC_RESET;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: secondary clock, strap, request-zero
	logic [2:0] meta_ff;          // first stage, read only by sync_ff
	logic [2:0] sync_ff;          // second stage, safe to use
	logic       clk_prev_ff;      // previous synchronised clock level
	logic [2:0] nxt_meta;
	logic [2:0] nxt_sync;
	logic       nxt_clk_prev;

	// next values of the synchroniser chain
	always_comb begin
		nxt_meta     = {sec_request_zero_i, ext_arb_enable_i, sec_clk_i};
		nxt_sync     = meta_ff;
		nxt_clk_prev = sync_ff[0];
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff     <= {1'b0, sbcr_pkg::PIN_SYNC_RESET};
			sync_ff     <= {1'b0, sbcr_pkg::PIN_SYNC_RESET};
			clk_prev_ff <= 1'b0;
		end else begin
			meta_ff     <= nxt_meta;
			sync_ff     <= nxt_sync;
			clk_prev_ff <= nxt_clk_prev;
		end
	end

	// secondary-facing logic keys off the clock input, never the fan-out
	assign sec_clk_rise_o = sync_ff[0] & ~clk_prev_ff;

	////////////////////////////////////////////////////////////////////////////////
	// arbitration mode capture: strap is taken once after release, then held
	sbcr_pkg::sbcr_arb_mode_e mode_ff;
	sbcr_pkg::sbcr_arb_mode_e nxt_mode;
	logic [1:0]               fill_ff;  // pin synchroniser holds real strap samples once bit 1 is set
	logic [1:0]               nxt_fill;

	// strap is only meaningful at start-up, so it is frozen after capture
	// the synchroniser leaves reset holding zeros; capturing before it has refilled
	// would always pick the internal arbiter, so capture waits for two pin samples
	always_comb begin
		nxt_fill = {fill_ff[0], 1'b1};
		nxt_mode = mode_ff;
		case (mode_ff)
			sbcr_pkg::SBCR_ARB_UNKNOWN: begin
				if (fill_ff[1]) begin
					nxt_mode = sync_ff[1] ? sbcr_pkg::SBCR_ARB_EXTERNAL : sbcr_pkg::SBCR_ARB_INTERNAL;
				end
			end
			sbcr_pkg::SBCR_ARB_INTERNAL: nxt_mode = sbcr_pkg::SBCR_ARB_INTERNAL;
			sbcr_pkg::SBCR_ARB_EXTERNAL: nxt_mode = sbcr_pkg::SBCR_ARB_EXTERNAL;
			default:                     nxt_mode = sbcr_pkg::SBCR_ARB_UNKNOWN;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= sbcr_pkg::SBCR_ARB_UNKNOWN;
			fill_ff <= sbcr_pkg::PIN_SYNC_RESET;
		end else begin
			mode_ff <= nxt_mode;
			fill_ff <= nxt_fill;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin role steering
	sbcr_pkg::sbcr_arb_pins_s pins_q; // synchronised request-zero, driven grant-zero
	logic                     ext_mode;
	logic                     int_mode;
	logic                     gnt_ff;
	logic                     ireq_ff;
	logic                     bgnt_ff;
	logic                     nxt_gnt;
	logic                     nxt_ireq;
	logic                     nxt_bgnt;

	assign ext_mode   = (mode_ff == sbcr_pkg::SBCR_ARB_EXTERNAL);
	assign int_mode   = (mode_ff == sbcr_pkg::SBCR_ARB_INTERNAL);
	assign ext_mode_o = ext_mode;

	// grant-zero pin: bridge request in external mode, internal grant in internal mode, low while the mode is unknown
	always_comb begin
		pins_q.req_zero_in  = sync_ff[2];
		pins_q.gnt_zero_out = 1'b0;
		nxt_ireq            = 1'b0;
		nxt_bgnt            = 1'b0;
		if (ext_mode) begin
			pins_q.gnt_zero_out = bridge_req_i;
			nxt_bgnt            = pins_q.req_zero_in;
		end else if (int_mode) begin
			pins_q.gnt_zero_out = int_grant_zero_i;
			nxt_ireq            = pins_q.req_zero_in;
		end
		nxt_gnt = pins_q.gnt_zero_out;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			gnt_ff  <= 1'b0;
			ireq_ff <= 1'b0;
			bgnt_ff <= 1'b0;
		end else begin
			gnt_ff  <= nxt_gnt;
			ireq_ff <= nxt_ireq;
			bgnt_ff <= nxt_bgnt;
		end
	end

	assign sec_grant_zero_o   = gnt_ff;
	assign int_request_zero_o = ireq_ff;
	assign bridge_gnt_o       = bgnt_ff;

	////////////////////////////////////////////////////////////////////////////////
	// clock fan-out and secondary reset
	// each secondary device gets its own copy; their sampling edges are their concern
	assign sec_clk_fanout_o = {CLK_COUNT{sec_clk_i}};

	// no flop on purpose: reset must assert even with the secondary clock stopped
	assign sec_reset_signal_n_o = pri_reset_signal_n_i & ~sec_rst_ctrl_i;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_reset_or_combo: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		sec_reset_signal_n_o == (pri_reset_signal_n_i && !sec_rst_ctrl_i))
		else $error("secondary reset not the or of its causes");

	a_fanout_follow: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		sec_clk_fanout_o == {CLK_COUNT{sec_clk_i}})
		else $error("clock fan-out differs from clock input");

	sequence s_clk_rise;
		!sync_ff[0] ##1 sync_ff[0];
	endsequence
	// the pulse stands in the same cycle as the first synchronised high sample
	a_rise_detect: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		s_clk_rise |-> sec_clk_rise_o)
		else $error("secondary clock rise missed");

	a_rise_single: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		sec_clk_rise_o |=> !sec_clk_rise_o)
		else $error("secondary clock rise pulse longer than one cycle");

	a_mode_stable: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		(mode_ff != sbcr_pkg::SBCR_ARB_UNKNOWN) |=> $stable(mode_ff))
		else $error("arbitration mode changed after capture");

	// capture is two steps: synchroniser refilled, then strap level taken
	sequence s_strap_high;
		(mode_ff == sbcr_pkg::SBCR_ARB_UNKNOWN) && fill_ff[1] && sync_ff[1];
	endsequence
	sequence s_strap_low;
		(mode_ff == sbcr_pkg::SBCR_ARB_UNKNOWN) && fill_ff[1] && !sync_ff[1];
	endsequence
	a_mode_capture: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		s_strap_high |=> ext_mode)
		else $error("strap high did not select external arbiter");

	a_mode_internal: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		s_strap_low |=> int_mode)
		else $error("strap low did not select internal arbiter");

	// nothing is steered onto the pins until the mode is known
	a_idle_routing: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		(mode_ff == sbcr_pkg::SBCR_ARB_UNKNOWN) |=> !sec_grant_zero_o && !bridge_gnt_o && !int_request_zero_o)
		else $error("pin routing active before mode capture");

	a_ext_request: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		ext_mode && $stable(ext_mode) |=> sec_grant_zero_o == $past(bridge_req_i))
		else $error("grant-zero pin does not carry bridge request");

	a_ext_grant: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		ext_mode |=> bridge_gnt_o == $past(sync_ff[2]) && !int_request_zero_o)
		else $error("request-zero not routed as grant in external mode");

	a_int_routing: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		int_mode |=> sec_grant_zero_o == $past(int_grant_zero_i) && !bridge_gnt_o)
		else $error("internal arbiter does not own grant-zero");

endmodule

// ---- verif/sbcr_far_model.sv ----
// Purpose: far side: bus clock source, one secondary device and an external arbiter
// Assumes: the bus clock runs free, as a bus clock does, at 125 ns
// Notes:   grant latency is set per run so prompt and slow arbiters are both seen
`timescale 1ns/1ps
module sbcr_far_model (
	input  wire logic       clk_fan_i,  // fanned-out clock that feeds this device
	input  wire logic       arb_ext_i,  // an external arbiter is fitted
	input  wire logic       dev_req_i,  // device wants the bus, internal mode
	input  wire logic       gnt_pin_i,  // grant-zero pin level
	input  wire logic [3:0] dly_i,      // clock rises before a grant
	output logic            sec_clk_o,  // bus clock source
	output logic            req_pin_o   // request-zero pin level
);
	logic [3:0] wait_cnt; // rises waited for a grant

	initial begin
		sec_clk_o = 1'b0;
		req_pin_o = 1'b0;
		wait_cnt  = 4'h0;
	end
	// free-running bus clock, off the system clock grid
	always #62.5 sec_clk_o = ~sec_clk_o;

	// sample only on the fed clock's rise, never on the source
	always @(posedge clk_fan_i) begin
		if (!arb_ext_i) begin
			req_pin_o <= dev_req_i;
			wait_cnt  <= 4'h0;
		end else if (!gnt_pin_i) begin
			req_pin_o <= 1'b0; // request gone: grant withdrawn
			wait_cnt  <= 4'h0;
		end else if (wait_cnt >= dly_i) begin
			req_pin_o <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule

// ---- verif/sbcr_top_bench.sv ----
// Purpose: self-checking bench for secondary clock, reset and arbitration mode
// Assumes: inputs change at the falling edge; the far side is the model
// Notes:   one task per scenario; a cycle ceiling cuts a hang short
`timescale 1ns/1ps
module sbcr_top_bench;
	logic       clk = 1'b0, nrst = 1'b0, strap = 1'b0, pri_n = 1'b1, ctrl = 1'b0; // drives
	logic       int_gnt = 1'b0, breq = 1'b0, dev_req = 1'b0, arb_ext = 1'b0;     // drives
	logic [3:0] dly = 4'h0;                                                        // grant latency
	logic       sec_clk, req_pin, rst_n, gnt_pin, int_req, br_gnt, ext_mode, rise; // seen
	logic [9:0] fan;                                                               // fan-out
	int         bad_count = 0, check_count = 0, cyc = 0, n;

	always #5 clk = ~clk;

	sbcr_top dut (.clk_sys_i(clk), .nrst_i(nrst), .sec_clk_i(sec_clk), .ext_arb_enable_i(strap),
		.pri_reset_signal_n_i(pri_n), .sec_rst_ctrl_i(ctrl), .sec_request_zero_i(req_pin),
		.int_grant_zero_i(int_gnt), .bridge_req_i(breq), .sec_clk_fanout_o(fan),
		.sec_reset_signal_n_o(rst_n), .sec_grant_zero_o(gnt_pin), .int_request_zero_o(int_req),
		.bridge_gnt_o(br_gnt), .ext_mode_o(ext_mode), .sec_clk_rise_o(rise));
	sbcr_far_model far (.clk_fan_i(fan[3]), .arb_ext_i(arb_ext), .dev_req_i(dev_req),
		.gnt_pin_i(gnt_pin), .dly_i(dly), .sec_clk_o(sec_clk), .req_pin_o(req_pin));

	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic do_reset(input logic s);
		@(negedge clk);
		nrst  = 1'b0;
		strap = s;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		repeat (6) @(negedge clk);
	endtask
	// reset out follows both causes with no clock edge between
	task automatic t_reset_out;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			pri_n = i[1];
			ctrl  = i[0];
			#1 chk("sec_reset_n", {9'h000, i[1] & ~i[0]}, {9'h000, rst_n});
		end
		ctrl = 1'b0;
	endtask
	// every copy equals the pin; rises counted over 1000 ns
	task automatic t_fanout;
		n = 0;
		repeat (100) begin
			@(negedge clk);
			chk("fanout", {10{sec_clk}}, fan);
			n += rise;
		end
		chk("rise_count", 10'h001, {9'h000, n >= 7 && n <= 9});
	endtask
	task automatic t_internal;
		arb_ext = 1'b0;
		do_reset(1'b0);
		chk("ext_mode", 10'h000, {9'h000, ext_mode});
		int_gnt = 1'b1;
		breq    = 1'b1;
		@(negedge clk);
		@(negedge clk);
		chk("grant_pin", 10'h001, {9'h000, gnt_pin});
		int_gnt = 1'b0;
		dev_req = 1'b1;
		for (n = 0; n < 60 && int_req !== 1'b1; n++) @(negedge clk);
		chk("int_req", 10'h001, {9'h000, int_req});
		chk("bridge_gnt", 10'h000, {9'h000, br_gnt});
		chk("grant_pin", 10'h000, {9'h000, gnt_pin});
		breq    = 1'b0;
		dev_req = 1'b0;
	endtask
	task automatic t_external(input logic [3:0] d);
		arb_ext = 1'b1;
		dly     = d;
		do_reset(1'b1);
		strap = 1'b0; // later strap changes are ignored
		repeat (5) @(negedge clk);
		chk("ext_mode", 10'h001, {9'h000, ext_mode});
		int_gnt = 1'b1;
		@(negedge clk);
		@(negedge clk);
		chk("grant_pin", 10'h000, {9'h000, gnt_pin});
		breq = 1'b1;
		for (n = 0; n < 120 && br_gnt !== 1'b1; n++) @(negedge clk);
		chk("grant_pin", 10'h001, {9'h000, gnt_pin});
		chk("bridge_gnt", 10'h001, {9'h000, br_gnt});
		chk("int_req", 10'h000, {9'h000, int_req});
		breq    = 1'b0;
		int_gnt = 1'b0;
	endtask

	// cycle ceiling well above the whole sequence
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		t_reset_out();
		do_reset(1'b0);
		t_fanout();
		t_internal();
		t_external(4'h0);
		t_external(4'h3);
		close_out();
	end
endmodule
